// [include/bus_release_defines.vh]
`ifndef BUS_RELEASE_DEFINES_VH
`define BUS_RELEASE_DEFINES_VH

// ----------------------------------------
// arbiter states
// ----------------------------------------
`define ARB_ST_W      2
`define ARB_ST_CORE   2'h0
`define ARB_ST_FLOAT  2'h1
`define ARB_ST_EXT    2'h2
`define ARB_ST_DMA    2'h3

// ----------------------------------------
// bus widths
// ----------------------------------------
`define ADDR_W        24
`define DATA_W        8
`define DMA_N         2

`endif

// [src/external_bus_release_arbiter.v]
`include "bus_release_defines.vh"
`default_nettype none

module external_bus_release_arbiter #(
  parameter ADDR_W = `ADDR_W,
  parameter DATA_W = `DATA_W,
  parameter DMA_N  = `DMA_N
) (
  // clock and reset
  input  wire              i_mclk,
  input  wire              i_rst_b,
  // external bus request and grant
  input  wire              i_bus_request_n,
  output reg               o_bus_grant_n,
  // core side bus
  input  wire [ADDR_W-1:0] i_core_addr,
  input  wire [DATA_W-1:0] i_core_wdata,
  input  wire              i_core_data_oe,
  input  wire              i_core_memory_request_n,
  input  wire              i_core_io_request_n,
  output wire              o_core_hold,
  // internal dma requests
  input  wire [DMA_N-1:0]  i_dma_req,
  output wire [DMA_N-1:0]  o_dma_gnt,
  // address pins
  input  wire [ADDR_W-1:0] i_addr,
  output wire [ADDR_W-1:0] o_addr,
  output wire              o_addr_oe,
  // data pins
  output wire [DATA_W-1:0] o_data,
  output wire              o_data_oe,
  // strobe pins
  input  wire              i_memory_request_n,
  input  wire              i_io_request_n,
  output wire              o_memory_request_n,
  output wire              o_io_request_n,
  output wire              o_ctrl_oe,
  // snooped outside cycle
  output reg  [ADDR_W-1:0] o_ext_addr,
  output reg               o_ext_memory_request_n,
  output reg               o_ext_io_request_n,
  // clock out
  output wire              o_system_clock_out
);

  // ----------------------------------------
  // arbiter states
  // ----------------------------------------
  localparam [`ARB_ST_W-1:0] ST_CORE  = `ARB_ST_CORE;
  localparam [`ARB_ST_W-1:0] ST_FLOAT = `ARB_ST_FLOAT;
  localparam [`ARB_ST_W-1:0] ST_EXT   = `ARB_ST_EXT;
  localparam [`ARB_ST_W-1:0] ST_DMA   = `ARB_ST_DMA;

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  reg  [`ARB_ST_W-1:0] state_q;
  reg  [`ARB_ST_W-1:0] state_d;
  reg  [DMA_N-1:0]     dma_gnt_q;
  reg  [DMA_N-1:0]     dma_gnt_d;
  wire                 dma_any;
  wire                 ext_req;
  wire [DMA_N-1:0]     dma_pick;
  wire                 in_core;
  wire                 in_float;
  wire                 in_ext;
  wire                 in_dma;

  assign dma_any  = |i_dma_req;
  assign ext_req  = ~i_bus_request_n;
  // lowest index wins; the mask needs DMA_N of two or more
  assign dma_pick = i_dma_req & ~(i_dma_req - {{(DMA_N-1){1'h0}}, 1'h1});
  assign in_core  = (state_q == ST_CORE);
  assign in_float = (state_q == ST_FLOAT);
  assign in_ext   = (state_q == ST_EXT);
  assign in_dma   = (state_q == ST_DMA);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always @* begin
    state_d   = state_q;
    dma_gnt_d = dma_gnt_q;
    case (state_q)
      ST_CORE: begin
        if (dma_any) begin
          state_d   = ST_DMA;
          dma_gnt_d = dma_pick;
        end else if (ext_req) begin
          state_d = ST_FLOAT;
        end
      end
      ST_FLOAT: begin
        // one cycle with pins floated before grant, so no fight on the bus
        if (dma_any) begin
          state_d   = ST_DMA;
          dma_gnt_d = dma_pick;
        end else if (ext_req) begin
          state_d = ST_EXT;
        end else begin
          state_d = ST_CORE;
        end
      end
      ST_EXT: begin
        // outside master keeps bus until it lets go; no pre-emption mid cycle
        if (!ext_req) begin
          state_d = ST_CORE;
        end
      end
      ST_DMA: begin
        if (!(|(i_dma_req & dma_gnt_q))) begin
          dma_gnt_d = {DMA_N{1'h0}};
          state_d   = ST_CORE;
        end
      end
      default: begin
        state_d   = ST_CORE;
        dma_gnt_d = {DMA_N{1'h0}};
      end
    endcase
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  // grant taken from the next state so it lands together with the state
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      state_q       <= ST_CORE;
      dma_gnt_q     <= {DMA_N{1'h0}};
      o_bus_grant_n <= 1'h1;
    end else begin
      state_q       <= state_d;
      dma_gnt_q     <= dma_gnt_d;
      o_bus_grant_n <= (state_d != ST_EXT);
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // core drives for itself and for a dma channel; float and outside grant let go
  wire       drive_core;
  wire [1:0] strobe_out;

  assign drive_core  = in_core | in_dma;
  assign o_core_hold = in_float | in_ext;
  assign o_dma_gnt   = dma_gnt_q;

  bus_pin_group #(
    .W (ADDR_W)
  ) u_addr_pins (
    .i_value (i_core_addr),
    .i_own   (drive_core),
    .i_want  (1'h1),
    .o_value (o_addr),
    .o_oe    (o_addr_oe)
  );

  bus_pin_group #(
    .W (DATA_W)
  ) u_data_pins (
    .i_value (i_core_wdata),
    .i_own   (drive_core),
    .i_want  (i_core_data_oe),
    .o_value (o_data),
    .o_oe    (o_data_oe)
  );

  bus_pin_group #(
    .W (2)
  ) u_strobe_pins (
    .i_value ({i_core_memory_request_n, i_core_io_request_n}),
    .i_own   (drive_core),
    .i_want  (1'h1),
    .o_value (strobe_out),
    .o_oe    (o_ctrl_oe)
  );

  assign o_memory_request_n = strobe_out[1];
  assign o_io_request_n     = strobe_out[0];

  // ----------------------------------------
  // outside master cycle capture
  // ----------------------------------------
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_ext_addr             <= {ADDR_W{1'h0}};
      o_ext_memory_request_n <= 1'h1;
      o_ext_io_request_n     <= 1'h1;
    end else if (in_ext) begin
      o_ext_addr             <= i_addr;
      o_ext_memory_request_n <= i_memory_request_n;
      o_ext_io_request_n     <= i_io_request_n;
    end else begin
      o_ext_memory_request_n <= 1'h1;
      o_ext_io_request_n     <= 1'h1;
    end
  end

  // ----------------------------------------
  // clock out
  // ----------------------------------------
  // clock forwarded directly; a gated copy would skew against the bus
  assign o_system_clock_out = i_mclk;

endmodule // external_bus_release_arbiter

// ----------------------------------------
// one group of bus pins
// ----------------------------------------
module bus_pin_group #(
  parameter W = 1
) (
  // core value and ownership
  input  wire [W-1:0] i_value,
  input  wire         i_own,
  input  wire         i_want,
  // pin drive
  output wire [W-1:0] o_value,
  output wire         o_oe
);

  // value always passes; only the enable decides whether the pins carry it
  assign o_value = i_value;
  assign o_oe    = i_own & i_want;

endmodule // bus_pin_group

`default_nettype wire

// [bench/arb_chk_assertions.sv]
`default_nettype none
module arb_chk (
  input wire logic        i_mclk, i_rst_b, i_bus_request_n, o_bus_grant_n, o_core_hold,
  input wire logic        o_addr_oe, o_data_oe, o_ctrl_oe,
  input wire logic [23:0] i_addr, o_ext_addr,
  input wire logic [1:0]  i_dma_req, o_dma_gnt
);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  a_float_first: assert property (!o_core_hold && !o_dma_gnt && !i_bus_request_n && !i_dma_req |=>
    !o_addr_oe && o_bus_grant_n) else $error("no float");
  a_grant_after: assert property ($fell(o_addr_oe) && !o_dma_gnt && !i_bus_request_n && !i_dma_req |=>
    !o_bus_grant_n) else $error("no grant");
  a_hold_float: assert property (!o_addr_oe |-> o_core_hold) else $error("no hold");
  a_pins_float: assert property (!o_bus_grant_n |-> !o_addr_oe && !o_data_oe && !o_ctrl_oe)
    else $error("pins driven");
  a_snoop_addr: assert property (!o_bus_grant_n [*2] |-> o_ext_addr == $past(i_addr)) else $error("snoop");
  a_dma_onehot: assert property ($onehot0(o_dma_gnt)) else $error("dma grant");
  a_dma_wins: assert property (!o_dma_gnt && o_bus_grant_n && |i_dma_req |=>
    o_dma_gnt == ($past(i_dma_req[0]) ? 2'h1 : 2'h2)) else $error("dma lost");
  a_one_owner: assert property (|o_dma_gnt |-> o_bus_grant_n) else $error("two owners");
  a_release_bus: assert property (!o_bus_grant_n && i_bus_request_n |=>
    o_bus_grant_n && o_addr_oe && o_ctrl_oe && !o_core_hold) else $error("no release");
endmodule // arb_chk
bind external_bus_release_arbiter arb_chk u_chk (.*);
`default_nettype wire

// [bench/ext_master_model.sv]
`default_nettype none
module ext_master_model (
  input  wire logic   i_mclk, i_grant_n,
  output logic        o_req_n, o_memory_request_n_n, o_ioreq_n,
  output logic [23:0] o_addr
);
  timeunit 1ns; timeprecision 1ps;
  int          seed = 1701;
  logic [25:0] exp_q [$];
  initial {o_req_n, o_memory_request_n_n, o_ioreq_n, o_addr} = {3'h7, 24'h00_0000};
  task automatic master(input int gap, input int len);
    repeat (gap + 1) @(negedge i_mclk);
    o_req_n = 1'b0;
    for (int i = 0; i < 40 && i_grant_n; i++) @(negedge i_mclk);
    repeat (len) begin
      {o_addr, o_memory_request_n_n, o_ioreq_n} = 26'($random(seed));
      exp_q.push_back({o_addr, o_memory_request_n_n, o_ioreq_n});
      @(negedge i_mclk);
    end
    // no pull on these lines, so show the inverse rather than a stale value
    {o_req_n, o_addr, o_memory_request_n_n, o_ioreq_n} = {1'b1, ~{o_addr, o_memory_request_n_n, o_ioreq_n}};
  endtask
endmodule // ext_master_model
`default_nettype wire

// [bench/external_bus_release_arbiter_tb_top.sv]
`default_nettype none
module external_bus_release_arbiter_tb_top;
  timeunit 1ns; timeprecision 1ps;
  logic        i_mclk = 0, i_rst_b = 0, i_bus_request_n, o_bus_grant_n, i_core_data_oe, i_core_memory_request_n;
  logic        i_core_io_request_n, o_core_hold, o_addr_oe, o_data_oe, i_memory_request_n, i_io_request_n;
  logic        o_memory_request_n, o_io_request_n, o_ctrl_oe, o_ext_memory_request_n, o_ext_io_request_n;
  logic        o_system_clock_out;
  logic [23:0] i_core_addr, i_addr, o_addr, o_ext_addr;
  logic [7:0]  i_core_wdata, o_data;
  logic [1:0]  i_dma_req = 2'h0, o_dma_gnt;
  logic [34:0] core = '0;
  int          fail_count = 0, samples_checked = 0;
  assign {i_core_addr, i_core_wdata, i_core_data_oe, i_core_memory_request_n, i_core_io_request_n} = core;
  external_bus_release_arbiter dut (.*);
  ext_master_model ext (.i_mclk, .i_grant_n(o_bus_grant_n), .o_req_n(i_bus_request_n), .o_addr(i_addr),
    .o_memory_request_n_n(i_memory_request_n), .o_ioreq_n(i_io_request_n));
  initial forever #12.5 i_mclk = ~i_mclk;
  always @(negedge i_mclk) core <= 35'({$random(ext.seed), $random(ext.seed)});
  task automatic cmp(input logic [25:0] g, input logic [25:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // checks and stimulus
  // ----------------------------------------
  always @(posedge i_mclk) begin
    #1;
    cmp(26'(o_system_clock_out), 26'h1);
    cmp(26'({o_addr, o_memory_request_n, o_io_request_n}), 26'({core[34:11], core[1:0]}));
    cmp(26'({o_data, o_data_oe}), 26'({core[10:3], core[2] & o_ctrl_oe}));
    if (ext.exp_q.size() > 0)
      cmp({o_ext_addr, o_ext_memory_request_n, o_ext_io_request_n}, ext.exp_q.pop_front());
  end
  initial begin
    repeat (16) @(negedge i_mclk);
    i_rst_b = 1'b1;
    ext.master(0, 4);
    ext.master(0, 1);
    ext.master(3, 2);
    $display("ext transfers done");
    for (int i = 0; i < 8; i++) begin
      @(negedge i_mclk) i_dma_req = 2'($random(ext.seed));
      @(negedge i_mclk) cmp(26'(o_dma_gnt), i_dma_req[0] ? 26'h1 : 26'(i_dma_req));
      i_dma_req = 2'h0;
    end
    fork
      ext.master(0, 2);
      begin
        @(negedge i_mclk) i_dma_req = 2'h2;
        repeat (2) @(negedge i_mclk);
        cmp(26'(o_dma_gnt), 26'h2);
        i_dma_req = 2'h0;
      end
    join
    $display("dma priority done");
    complete_run;
  end
  initial begin
    repeat (2000) @(posedge i_mclk);
    fail_count++;
    complete_run;
  end
endmodule // external_bus_release_arbiter_tb_top
`default_nettype wire
